// file: core/hbp_pkg.sv
// Constants and carrier types for the host bus byte lane port
package hbp_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int QDEPTH = 64;
  localparam int PTR_W = 6;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] QUEUE_FULL = 7'h40;
  // Word address shared by both queues; direction picks the queue
  localparam logic [ADDR_W-2:0] QUEUE_WORD = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [PTR_W-1:0] PTR_RST = 6'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 7'h00;

  typedef enum logic [1:0] {
    ST_IDLE, ST_READ, ST_HOLD, ST_WRITE
  } hbp_state_t;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic ale;
    logic lane_strobe_n;
    logic bus_width_select;
    logic style_alt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } hbp_pins_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [1:0] be;
    logic [DATA_W-1:0] wdata;
  } hbp_reg_req_t;

  typedef struct packed {
    hbp_pins_t meta;
    hbp_pins_t sync;
    logic ale_prev;
    logic mux;
    logic [ADDR_W-1:0] laddr;
    hbp_state_t st;
    logic [ADDR_W-1:0] acc_addr;
    logic [1:0] acc_nb;
    logic acc_hi0;
    logic acc_hi1;
    logic [DATA_W-1:0] wbuf;
    logic [DATA_W-1:0] dout;
    logic [QDEPTH-1:0][7:0] rx_mem;
    logic [PTR_W-1:0] rx_head;
    logic [PTR_W-1:0] rx_tail;
    logic [CNT_W-1:0] rx_cnt;
    logic [QDEPTH-1:0][7:0] tx_mem;
    logic [PTR_W-1:0] tx_head;
    logic [PTR_W-1:0] tx_tail;
    logic [CNT_W-1:0] tx_cnt;
  } hbp_state_reg_t;
endpackage : hbp_pkg

// file: core/hbp_host_port.sv
// Host bus byte lane port with receive and transmit byte queues
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (RL1) Either strobe style is chosen by a pin, and the bus is 8 or 16 bits.
// (RL2) Registers are reached directly by address, with no indirection.
// (RL3) Every register access is taken as one byte or one 16-bit word.
// (RL4) On the 16-bit bus the lanes follow the lowest address bit and strobe.
// (RL5) Upper strobe style: word, odd byte high lane, even byte low, or none.
// (RL6) Other style: word, odd byte low lane, even byte high lane, or none.
// (RL7) A toggling address latch means a multiplexed bus, else demultiplexed.
// (RL8) Each direction has a 64-byte queue reached through the host port.
// (RL9) Queue access is byte or word by bus mode; words only on 16 bits.
// (RL10) Mixed byte and word queue accesses keep every byte in order.
// (RL11) The board holds the width select high to pick the 16-bit bus.
// (RL12) On the 8-bit bus all goes on the low lane; the strobe is ignored.
module hbp_host_port
  import hbp_pkg::*;
(
  input wire logic core_clk, // 25 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire hbp_pins_t pins, // Host bus pins, asynchronous
  output logic [DATA_W-1:0] data_out, // Read data to the bus
  output logic [1:0] data_oe, // Lane drive enables {high, low}
  output hbp_reg_req_t reg_req, // Register access to the core
  input wire logic [DATA_W-1:0] reg_rdata, // Register read data
  input wire logic rx_in_valid, // Receive byte offered
  input wire logic [7:0] rx_in_data, // Receive byte
  output logic rx_in_ready, // Receive queue has room
  output logic tx_out_valid, // Transmit byte available
  output logic [7:0] tx_out_data, // Transmit byte
  input wire logic tx_out_ready // Transmit byte taken
);

  hbp_state_reg_t s;
  hbp_state_reg_t next_s;

  logic rd_on;
  logic wr_on;
  logic [ADDR_W-1:0] addr_now;
  logic [1:0] nb_now;
  logic hi0_now;
  logic hi1_now;
  logic is_queue;
  logic [7:0] byte0;
  logic [7:0] byte1;
  logic [1:0] rx_pop;
  logic [1:0] tx_push;
  logic rx_push;
  logic tx_pop;
  logic [CNT_W-1:0] tx_free;

  always_comb begin
    next_s = s;
    reg_req = '0;
    rx_pop = 2'd0;
    tx_push = 2'd0;
    byte0 = 8'h00;
    byte1 = 8'h00;
    next_s.meta = pins;
    next_s.sync = s.meta;

    // Any movement on the latch pin means a multiplexed bus
    next_s.ale_prev = s.sync.ale;
    if (s.sync.ale != s.ale_prev) begin
      next_s.mux = 1'b1; // [RL7]
    end
    if (s.ale_prev && !s.sync.ale) begin
      next_s.laddr = s.sync.data[ADDR_W-1:0]; // [RL7]
    end
    addr_now = s.mux ? s.laddr : s.sync.addr; // [RL7]

    rd_on = !s.sync.cs_n && !s.sync.rd_n;
    wr_on = !s.sync.cs_n && !s.sync.wr_n;

    // Lane decode; a byte at odd parity sits high unless style is swapped
    if (!s.sync.bus_width_select) begin // [RL1]
      nb_now = 2'd1; // [RL12]
      hi0_now = 1'b0; // [RL12]
      hi1_now = 1'b0;
    end else begin
      hi0_now = addr_now[0] ^ s.sync.style_alt; // [RL4] [RL5] [RL6]
      hi1_now = !s.sync.style_alt; // [RL1] [RL5] [RL6]
      unique case ({s.sync.lane_strobe_n, addr_now[0]})
        2'b00: nb_now = 2'd2; // [RL3] [RL5] [RL6]
        2'b01: nb_now = 2'd1; // [RL5] [RL6]
        2'b10: nb_now = 2'd1; // [RL5] [RL6]
        2'b11: nb_now = 2'd0; // [RL5] [RL6]
      endcase
    end
    is_queue = s.acc_addr[ADDR_W-1:1] == QUEUE_WORD; // [RL8]

    tx_free = QUEUE_FULL - s.tx_cnt;

    unique case (s.st)
      ST_IDLE: begin
        next_s.acc_addr = addr_now;
        next_s.acc_nb = nb_now;
        next_s.acc_hi0 = hi0_now;
        next_s.acc_hi1 = hi1_now;
        if (rd_on && nb_now != 2'd0) begin
          next_s.st = ST_READ;
        end else if (wr_on) begin
          next_s.st = ST_WRITE;
          next_s.wbuf = s.sync.data;
        end
      end
      ST_READ: begin
        if (is_queue) begin
          // Short queue gives what it holds; missing bytes read zero
          if (s.rx_cnt < {5'd0, s.acc_nb}) begin
            rx_pop = s.rx_cnt[1:0]; // [RL10]
          end else begin
            rx_pop = s.acc_nb; // [RL9] [RL10]
          end
          if (rx_pop != 2'd0) begin
            byte0 = s.rx_mem[s.rx_head];
          end
          if (rx_pop == 2'd2) begin
            byte1 = s.rx_mem[s.rx_head + PTR_W'(1)];
          end
        end else begin
          reg_req.req = 1'b1; // [RL2]
          reg_req.addr = s.acc_addr;
          reg_req.be = (s.acc_nb == 2'd2) ? 2'b11 : 2'b01; // [RL3]
          byte0 = reg_rdata[7:0];
          byte1 = reg_rdata[15:8];
        end
        next_s.dout = DATA_RST;
        if (s.acc_hi0) begin
          next_s.dout[15:8] = byte0; // [RL5] [RL6]
        end else begin
          next_s.dout[7:0] = byte0; // [RL5] [RL6] [RL12]
        end
        if (s.acc_nb == 2'd2) begin
          if (s.acc_hi1) begin
            next_s.dout[15:8] = byte1; // [RL5] [RL6]
          end else begin
            next_s.dout[7:0] = byte1; // [RL5] [RL6]
          end
        end
        next_s.st = ST_HOLD;
      end
      ST_HOLD: begin
        if (!rd_on && !wr_on) begin
          next_s.st = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (wr_on) begin
          // Track bus until release; data settles before the strobe ends
          next_s.wbuf = s.sync.data;
          next_s.acc_addr = addr_now;
          next_s.acc_nb = nb_now;
          next_s.acc_hi0 = hi0_now;
          next_s.acc_hi1 = hi1_now;
        end else begin
          next_s.st = ST_IDLE;
          byte0 = s.acc_hi0 ? s.wbuf[15:8] : s.wbuf[7:0]; // [RL5] [RL6]
          // Unused lane of a byte access stays zero toward the registers
          if (s.acc_nb == 2'd2) begin
            byte1 = s.acc_hi1 ? s.wbuf[15:8] : s.wbuf[7:0]; // [RL5] [RL6]
          end
          if (is_queue) begin
            // Bytes beyond the free room are dropped
            if (tx_free < {5'd0, s.acc_nb}) begin
              tx_push = tx_free[1:0]; // [RL10]
            end else begin
              tx_push = s.acc_nb; // [RL9] [RL10]
            end
            if (tx_push != 2'd0) begin
              next_s.tx_mem[s.tx_tail] = byte0;
            end
            if (tx_push == 2'd2) begin
              next_s.tx_mem[s.tx_tail + PTR_W'(1)] = byte1;
            end
          end else if (s.acc_nb != 2'd0) begin
            reg_req.req = 1'b1; // [RL2]
            reg_req.wr = 1'b1;
            reg_req.addr = s.acc_addr;
            reg_req.be = (s.acc_nb == 2'd2) ? 2'b11 : 2'b01; // [RL3]
            reg_req.wdata = {byte1, byte0};
          end
        end
      end
    endcase

    // Receive queue: core fills, host drains
    rx_push = rx_in_valid && (s.rx_cnt != QUEUE_FULL);
    if (rx_push) begin
      next_s.rx_mem[s.rx_tail] = rx_in_data; // [RL8]
      next_s.rx_tail = s.rx_tail + PTR_W'(1);
    end
    next_s.rx_head = s.rx_head + PTR_W'(rx_pop);
    next_s.rx_cnt = s.rx_cnt + CNT_W'(rx_push) - CNT_W'(rx_pop);

    // Transmit queue: host fills, core drains
    tx_pop = (s.tx_cnt != CNT_RST) && tx_out_ready;
    next_s.tx_tail = s.tx_tail + PTR_W'(tx_push);
    if (tx_pop) begin
      next_s.tx_head = s.tx_head + PTR_W'(1); // [RL8]
    end
    next_s.tx_cnt = s.tx_cnt + CNT_W'(tx_push) - CNT_W'(tx_pop);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.laddr <= ADDR_RST;
      s.dout <= DATA_RST;
      s.rx_head <= PTR_RST;
      s.rx_tail <= PTR_RST;
      s.rx_cnt <= CNT_RST;
      s.tx_head <= PTR_RST;
      s.tx_tail <= PTR_RST;
      s.tx_cnt <= CNT_RST;
    end else begin
      s <= next_s;
    end
  end

  assign data_out = s.dout;
  // Drive only while the host still reads, so the bus is released promptly
  assign data_oe[1] = (s.st == ST_HOLD) && rd_on &&
                      (s.acc_hi0 || (s.acc_nb == 2'd2 && s.acc_hi1));
  assign data_oe[0] = (s.st == ST_HOLD) && rd_on &&
                      (!s.acc_hi0 || (s.acc_nb == 2'd2 && !s.acc_hi1));
  assign rx_in_ready = s.rx_cnt != QUEUE_FULL;
  assign tx_out_valid = s.tx_cnt != CNT_RST;
  assign tx_out_data = s.tx_mem[s.tx_head];

endmodule : hbp_host_port

`default_nettype wire

// file: sim/hbp_host_port_chk.sv
// Assertions on the host bus byte lane port
`timescale 1ns/1ps
`default_nettype none
module hbp_host_port_chk
  import hbp_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire hbp_pins_t pins, // Host bus pins
  input wire logic [1:0] data_oe, // Lane enables
  input wire hbp_reg_req_t reg_req, // Register access
  input wire logic tx_out_valid, // Transmit byte valid
  input wire logic [7:0] tx_out_data, // Transmit byte
  input wire logic tx_out_ready // Transmit byte taken
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  req_single_pulse_a: assert property (reg_req.req |=> !reg_req.req)
    else $error("register request lasted two cycles");
  req_has_lane_a: assert property (reg_req.req |-> reg_req.be != 2'h0)
    else $error("register request without byte enable");
  narrow_byte_a: assert property (reg_req.req && !pins.bus_width_select
    |-> reg_req.be == 2'h1)
    else $error("narrow bus request not single byte");
  word_even_a: assert property (reg_req.req && reg_req.be == 2'h3
    |-> !reg_req.addr[0])
    else $error("word access at odd address");
  oe_after_read_a: assert property (data_oe != 2'h0
    |-> !$past(pins.rd_n, 2))
    else $error("lanes driven without read strobe");
  narrow_lane_a: assert property (data_oe != 2'h0 && !pins.bus_width_select
    |-> data_oe == 2'h1)
    else $error("narrow bus read off the low lane");
  no_transfer_a: assert property (data_oe != 2'h0 && pins.bus_width_select
    |-> !(pins.lane_strobe_n && pins.addr[0]))
    else $error("lanes driven on no transfer decode");
  tx_hold_a: assert property (tx_out_valid && !tx_out_ready
    |=> tx_out_valid && $stable(tx_out_data))
    else $error("transmit byte changed before taken");
  cover property (reg_req.req && reg_req.wr && reg_req.be == 2'h3);
  cover property (data_oe == 2'h3);
  cover property (tx_out_valid && tx_out_ready);
endmodule : hbp_host_port_chk
bind hbp_host_port hbp_host_port_chk i_hbp_host_port_chk (
  .core_clk(core_clk), .rstn(rstn), .pins(pins), .data_oe(data_oe),
  .reg_req(reg_req), .tx_out_valid(tx_out_valid),
  .tx_out_data(tx_out_data), .tx_out_ready(tx_out_ready));
`default_nettype wire

// file: sim/hbp_reg_model.sv
// Register store answering the port's register requests
`timescale 1ns/1ps
`default_nettype none
module hbp_reg_model
  import hbp_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire hbp_reg_req_t req, // Register access
  output logic [DATA_W-1:0] rdata // Read data
);
  logic [7:0] mem [256] = '{default: 8'h00};
  logic [DATA_W-1:0] val;
  assign val = {mem[8'(req.addr + 1)], mem[req.addr]};
  // Scrambled outside requests so stale data never passes
  assign rdata = req.req ? val : ~val;
  always @(posedge core_clk) begin
    if (req.req && req.wr) begin
      mem[req.addr] <= req.wdata[7:0];
      if (req.be[1]) mem[8'(req.addr + 1)] <= req.wdata[15:8];
    end
  end
endmodule : hbp_reg_model
`default_nettype wire

// file: sim/test_host_bus_byte_lane_port.sv
// Self-checking bench for the host bus byte lane port
`timescale 1ns/1ps
`default_nettype none
module test_host_bus_byte_lane_port
  import hbp_pkg::*;
;
  logic core_clk = 0, rstn = 0, rx_in_valid = 0, rx_in_ready, tx_out_ready = 0;
  logic tx_out_valid, oe_prev = 0;
  logic [7:0] rx_in_data = 8'h00, tx_out_data, x, y, sh [256] = '{default: 0};
  logic [1:0] data_oe;
  logic [DATA_W-1:0] data_out, reg_rdata;
  hbp_pins_t p = '{cs_n: 1, rd_n: 1, wr_n: 1, lane_strobe_n: 1, default: 0};
  hbp_reg_req_t reg_req;
  logic [26:0] q [$];
  logic [7:0] txq [$], rxm [$];
  logic [26:0] seen, want;
  bit strobe, mx = 0;
  int num_errors = 0, total_checks = 0, cyc = 0, i, k;
  hbp_host_port i_hbp_host_port (.core_clk(core_clk), .rstn(rstn), .pins(p),
    .data_out(data_out), .data_oe(data_oe), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .rx_in_valid(rx_in_valid),
    .rx_in_data(rx_in_data), .rx_in_ready(rx_in_ready),
    .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
    .tx_out_ready(tx_out_ready));
  hbp_reg_model i_hbp_reg_model (.core_clk(core_clk), .req(reg_req),
    .rdata(reg_rdata));
  initial forever #20 core_clk = ~core_clk;
  task automatic chk(logic [26:0] got, logic [26:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  // {lane enables, pins} for byte x at addr and y at addr+1
  function automatic logic [17:0] lane(bit wd, sty, stb, a0,
                                       logic [7:0] x, y);
    if (!wd) return {2'h1, 8'h00, x};
    if (!stb && !a0) return sty ? {2'h3, x, y} : {2'h3, y, x};
    return (a0 ^ sty) ? {2'h2, x, 8'h00} : {2'h1, 8'h00, x};
  endfunction : lane
  task automatic op(bit w, wd, sty, stb, logic [7:0] a, x, y);
    logic [17:0] l;
    bit none, word;
    l = lane(wd, sty, stb, a[0], x, y);
    none = wd && stb && a[0];
    word = wd && !stb && !a[0];
    if (!none && w && a > 1) begin
      q.push_back({1'b1, a, word ? 2'h3 : 2'h1, word ? y : 8'h00, x});
      sh[a] = x;
      if (word) sh[8'(a + 1)] = y;
    end else if (!none && w) begin
      txq.push_back(x);
      if (word) txq.push_back(y);
    end else if (!none) q.push_back({9'h000, l});
    p.cs_n <= 0;
    p.rd_n <= w;
    p.wr_n <= !w;
    // Address pins lie in mux mode so only the latched address can work
    p.addr <= mx ? a ^ 8'hFE : a;
    p.data <= l[15:0];
    p.lane_strobe_n <= stb;
    p.bus_width_select <= wd;
    p.style_alt <= sty;
    repeat (8) @(posedge core_clk);
    p.cs_n <= 1;
    p.rd_n <= 1;
    p.wr_n <= 1;
    p.data <= ~l[15:0];
    repeat (6) @(posedge core_clk);
  endtask : op
  // Address phase on the data lines, taken at the latch falling edge
  task automatic latch(logic [7:0] a);
    p.ale <= 1'b1;
    p.data <= {8'h00, a};
    repeat (2) @(posedge core_clk);
    p.ale <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : latch
  always @(posedge core_clk) begin
    tx_out_ready <= 1'($urandom);
    oe_prev <= data_oe != 2'h0;
    if (reg_req.req && reg_req.wr) begin
      seen = {1'b1, reg_req.addr, reg_req.be, reg_req.wdata};
      want = q.size() ? q.pop_front() : 'x;
      chk(seen, want);
    end
    if (data_oe != 2'h0 && !oe_prev) begin
      seen = {9'h000, data_oe,
              data_out & {{8{data_oe[1]}}, {8{data_oe[0]}}}};
      want = q.size() ? q.pop_front() : 'x;
      chk(seen, want);
    end
    if (tx_out_valid && tx_out_ready) begin
      want = txq.size() ? 27'(txq.pop_front()) : 'x;
      chk(27'(tx_out_data), want);
    end
    if (++cyc == 6000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'hEDE37B14));
    repeat (16) @(posedge core_clk);
    rstn <= 1;
    @(posedge core_clk);
    // Every lane decode, then the narrow bus, in each of the two styles
    for (i = 0; i < 12; i++) begin
      k = i % 6;
      x = 8'(($urandom_range(1, 127) << 1) | k % 2);
      strobe = k < 4 ? 1'(k / 2) : 1'($urandom);
      op(1, k < 4, i / 6, strobe, x, 8'($urandom), 8'($urandom));
      op(0, k < 4, i / 6, strobe, x, sh[x], sh[8'(x + 1)]);
    end
    for (i = 0; i < 10; i++) op(1, i < 8, i % 2, 1'($urandom), 8'h00,
      8'($urandom), 8'($urandom));
    for (i = 0; i < 64; i++) begin
      rxm.push_back(8'($urandom));
      rx_in_data <= rxm[i];
      rx_in_valid <= 1;
      @(posedge core_clk);
    end
    rx_in_valid <= 0;
    #1 chk(27'(rx_in_ready), 27'h0);
    // Mixed byte and word drain keeps byte order
    while (rxm.size()) begin
      k = rxm.size() > 1 ? 1'($urandom) : 0;
      x = rxm.pop_front();
      y = k ? rxm.pop_front() : 8'h00;
      op(0, 1, 1'($urandom), !k, 8'h00, x, y);
    end
    // Multiplexed bus last, since the mode sticks until reset
    mx = 1;
    for (i = 0; i < 4; i++) begin
      x = 8'($urandom_range(1, 126) << 1);
      latch(x);
      op(1, 1, i % 2, 0, x, 8'($urandom), 8'($urandom));
      latch(x);
      op(0, 1, i % 2, 0, x, sh[x], sh[8'(x + 1)]);
    end
    for (i = 0; i < 200 && txq.size(); i++) @(posedge core_clk);
    chk(27'(txq.size() + q.size()), 27'h0);
    conclude();
  end
endmodule : test_host_bus_byte_lane_port
`default_nettype wire
